// [src/spi_nand_feature_regs.sv]
// Purpose: Serial flash feature bank, command framing and busy timing.
// Assumes: Host keeps serial clock idle while select is high.
// Notes: Feature bank lives on the serial clock; busy timer on core clock.

`timescale 1ns/1ps

// Contract
// R1: Serial modes 0 and 3 are supported.
// R2: Sample on rising edge, shift out falling.
// R3: Host keeps clock idle while deselected.
// R4: Host respects minimum deselect between commands.
// R5: 0Fh reads, 1Fh writes feature by address.
// R6: Settings survive reset command, lost at power.
// R7: Lock settings layout at address A0h.
// R8: Configuration layout at address B0h.
// R9: Status layout at address C0h.
// R10: Drive strength in bits 6:5 at D0h.
// R11: Lock settings power up as 7Ch.
// R12: All lock settings bits are writable.
// R13: Host sets guards before freezing settings.
// R14: Program busy within maximum program time.
// R15: Host limits partial programs per page.
// R16: Page read busy within maximum read time.
// R17: Reset busy limit depends on current operation.
// R18: First reset after power may take longer.
// R19: Reserved bits ignore writes, read zero.
module spi_nand_feature_regs import nand_feature_pkg::*; #(
	parameter int PROG_CYCLES = PROG_CYC,
	parameter int READ_CYCLES = READ_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int RST_IDLE_CYCLES = RST_IDLE_CYC,
	parameter int RST_READ_CYCLES = RST_READ_CYC,
	parameter int RST_PROG_CYCLES = RST_PROG_CYC,
	parameter int RST_ERASE_CYCLES = RST_ERASE_CYC,
	parameter int RST_FIRST_CYCLES = RST_FIRST_CYC,
	parameter logic [7:0] ERASE_OPCODE = 8'hD8
) (
	// Core clock and power-on reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Serial link from the host
	input wire logic SPI_SCK,
	input wire logic SPI_CS_N,
	input wire logic SPI_MOSI,
	output logic SPI_MISO_O,
	output logic SPI_MISO_OE,
	// Array status from core logic
	input wire logic [1:0] ECC_STATUS,
	input wire logic PROGRAM_FAIL,
	input wire logic ERASE_FAIL,
	input wire logic WRITE_LATCH,
	// Settings and state towards the array
	output logic [7:0] LOCK_SETTINGS,
	output logic [7:0] CONFIG_SETTINGS,
	output logic [1:0] DRIVE_STRENGTH,
	output logic OP_BUSY
);

	// ==========================================================
	// Serial framing, serial clock domain

	logic frame_rst;
	logic [2:0] bit_cnt_q;
	logic [6:0] shift_q;
	frame_state_type state_q;
	frame_state_type state_d;
	logic [7:0] opcode_q;
	logic [7:0] addr_q;
	logic start_tog_q;
	op_kind_type kind_q;
	op_kind_type kind_d;
	logic [7:0] lock_q;
	logic [7:0] config_q;
	logic [7:0] drive_q;
	logic [7:0] tx_q;
	logic oe_q;
	logic [STAT_W-1:0] stat_s;
	logic busy_q;

	wire [7:0] rx_byte = {shift_q, SPI_MOSI};
	wire byte_done = (bit_cnt_q == BIT_LAST);
	wire is_get = (opcode_q == OPC_GET_FEATURE);
	wire is_set = (opcode_q == OPC_SET_FEATURE);
	wire is_array_op = (rx_byte == OPC_PROGRAM_EXEC) ||
		(rx_byte == OPC_PAGE_READ) || (rx_byte == ERASE_OPCODE) ||
		(rx_byte == OPC_RESET);
	wire op_start = (state_q == FR_OPCODE) && byte_done && is_array_op;
	wire set_done = (state_q == FR_DATA) && byte_done && is_set;

	// Deselect ends the frame without needing a clock edge
	assign frame_rst = RST | SPI_CS_N; // R3

	// Kind of array operation named by the opcode
	assign kind_d = (rx_byte == OPC_PROGRAM_EXEC) ? OP_PROGRAM :
		(rx_byte == OPC_PAGE_READ) ? OP_READ :
		(rx_byte == OPC_RESET) ? OP_RESET : OP_ERASE;

	// Frame sequencer: opcode, feature address, then data bytes
	always_comb begin
		state_d = state_q;
		if (byte_done) begin
			case (state_q)
				FR_OPCODE: begin
					if (rx_byte == OPC_GET_FEATURE ||
						rx_byte == OPC_SET_FEATURE) begin
						state_d = FR_ADDR; // R5
					end else begin
						state_d = FR_IGNORE;
					end
				end
				FR_ADDR: state_d = FR_DATA;
				FR_DATA: state_d = is_set ? FR_IGNORE : FR_DATA;
				FR_IGNORE: state_d = FR_IGNORE;
				default: state_d = FR_IGNORE;
			endcase
		end
	end

	// Inputs sampled on the rising edge in both modes
	always_ff @(posedge SPI_SCK or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt_q <= BIT_FIRST;
			shift_q <= '0;
			state_q <= FR_OPCODE;
		end else begin
			bit_cnt_q <= bit_cnt_q + 3'h1; // R1 R2
			shift_q <= rx_byte[6:0];
			state_q <= state_d;
		end
	end

	// Opcode and address survive to the end of the frame
	always_ff @(posedge SPI_SCK or posedge frame_rst) begin
		if (frame_rst) begin
			opcode_q <= BYTE_ZERO;
			addr_q <= BYTE_ZERO;
		end else begin
			if (state_q == FR_OPCODE && byte_done) begin
				opcode_q <= rx_byte;
			end
			if (state_q == FR_ADDR && byte_done) begin
				addr_q <= rx_byte; // R5
			end
		end
	end

	// Start event is a toggle so it survives the clock stopping
	always_ff @(posedge SPI_SCK or posedge RST) begin
		if (RST) begin
			start_tog_q <= 1'b0;
			kind_q <= OP_RESET;
		end else if (op_start) begin
			start_tog_q <= ~start_tog_q;
			kind_q <= kind_d;
		end
	end

	// ==========================================================
	// Feature bank, serial clock domain

	// Guard pair decides if the freeze bit may be set
	wire guards_set = lock_q[LOCK_GUARD_A_BIT] & lock_q[LOCK_GUARD_B_BIT];
	// Guard B alone also freezes the lock settings until power is lost
	wire lock_frozen = config_q[CFG_FREEZE_BIT] |
		(lock_q[LOCK_GUARD_B_BIT] & ~lock_q[LOCK_GUARD_A_BIT]);
	wire lock_wr = set_done && addr_q == ADDR_LOCK && !lock_frozen;
	wire config_wr = set_done && addr_q == ADDR_CONFIG;
	wire drive_wr = set_done && addr_q == ADDR_DRIVE;
	// Lock and freeze bits can only be set; volatile bits follow data
	wire [7:0] config_wdata = (rx_byte & CFG_VOLATILE_MASK) |
		(config_q & CFG_STICKY_MASK) | (rx_byte & CFG_OTP_LOCK_MASK) |
		((guards_set ? rx_byte : BYTE_ZERO) & CFG_FREEZE_MASK); // R8

	// Only power-on reset clears the bank; the reset opcode does not
	always_ff @(posedge SPI_SCK or posedge RST) begin
		if (RST) begin
			lock_q <= LOCK_RESET; // R11
			config_q <= CONFIG_RESET;
			drive_q <= DRIVE_RESET;
		end else begin
			if (lock_wr) begin
				lock_q <= rx_byte & feature_mask(ADDR_LOCK); // R7 R12
			end
			if (config_wr) begin
				config_q <= config_wdata; // R6
			end
			if (drive_wr) begin
				drive_q <= rx_byte & feature_mask(ADDR_DRIVE); // R10 R19
			end
		end
	end

	// Status bits arrive as levels from the core clock domain
	bit_sync #(
		.WIDTH(STAT_W)
	) u_stat_sync (
		.clk(SPI_SCK),
		.rst(RST),
		.d({ECC_STATUS, PROGRAM_FAIL, ERASE_FAIL, WRITE_LATCH, busy_q}),
		.q(stat_s)
	);

	// Read selection; the mask zeroes reserved positions
	wire [7:0] status_rd = {2'h0, stat_s}; // R9
	wire [7:0] rd_raw = (addr_q == ADDR_LOCK) ? lock_q :
		(addr_q == ADDR_CONFIG) ? config_q :
		(addr_q == ADDR_STATUS) ? status_rd :
		(addr_q == ADDR_DRIVE) ? drive_q : BYTE_ZERO;
	wire [7:0] rd_value = rd_raw & feature_mask(addr_q); // R19

	// Output shifts on the falling edge; value refreshes every byte
	always_ff @(negedge SPI_SCK or posedge frame_rst) begin
		if (frame_rst) begin
			tx_q <= BYTE_ZERO;
			oe_q <= 1'b0;
		end else if (state_q == FR_DATA && is_get) begin
			oe_q <= 1'b1;
			if (bit_cnt_q == BIT_FIRST) begin
				tx_q <= rd_value; // R2 R5
			end else begin
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end

	assign SPI_MISO_O = tx_q[7];
	assign SPI_MISO_OE = oe_q;
	assign LOCK_SETTINGS = lock_q;
	assign CONFIG_SETTINGS = config_q;
	assign DRIVE_STRENGTH = drive_q[DRV_HI_BIT:DRV_LO_BIT];

	// ==========================================================
	// Busy timer, core clock domain

	logic [2:0] start_s;
	logic tog_seen_q;
	logic ev_q;
	logic first_q;
	op_kind_type cur_op_q;
	logic [CNT_W-1:0] cnt_q;

	bit_sync #(
		.WIDTH(3)
	) u_start_sync (
		.clk(CORE_CLK),
		.rst(RST),
		.d({start_tog_q, 2'(kind_q)}),
		.q(start_s)
	);

	// Event acted on a cycle late so the kind bits have settled
	wire start_ev = start_s[2] ^ tog_seen_q;
	wire op_kind_type kind_in = op_kind_type'(start_s[1:0]);
	wire is_reset = (kind_in == OP_RESET);
	// A new array operation other than reset is ignored while one is running
	wire load = ev_q && (is_reset || !busy_q);

	// Reset limit follows what the device is doing at that moment
	wire [CNT_W-1:0] reset_limit = first_q ? CNT_W'(RST_FIRST_CYCLES - 1) :
		!busy_q ? CNT_W'(RST_IDLE_CYCLES - 1) :
		(cur_op_q == OP_READ) ? CNT_W'(RST_READ_CYCLES - 1) :
		(cur_op_q == OP_PROGRAM) ? CNT_W'(RST_PROG_CYCLES - 1) :
		(cur_op_q == OP_ERASE) ? CNT_W'(RST_ERASE_CYCLES - 1) :
		CNT_W'(RST_IDLE_CYCLES - 1); // R17 R18
	wire [CNT_W-1:0] op_limit = (kind_in == OP_PROGRAM) ?
		CNT_W'(PROG_CYCLES - 1) :
		(kind_in == OP_READ) ? CNT_W'(READ_CYCLES - 1) :
		CNT_W'(ERASE_CYCLES - 1); // R14 R16

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			tog_seen_q <= 1'b0;
			ev_q <= 1'b0;
		end else begin
			tog_seen_q <= start_s[2];
			ev_q <= start_ev;
		end
	end

	// Busy flag stays up for the whole count
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			busy_q <= 1'b0;
			cnt_q <= '0;
			cur_op_q <= OP_RESET;
			first_q <= 1'b1;
		end else if (load) begin
			busy_q <= 1'b1; // R14
			cnt_q <= is_reset ? reset_limit : op_limit;
			cur_op_q <= kind_in;
			first_q <= first_q & ~is_reset; // R18
		end else if (busy_q) begin
			cnt_q <= cnt_q - CNT_W'(1);
			busy_q <= (cnt_q != '0);
		end
	end

	assign OP_BUSY = busy_q;

	// ==========================================================
	// Checks

	prog_load_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R14
		ev_q && !busy_q && kind_in == OP_PROGRAM |=>
		busy_q && cnt_q == CNT_W'(PROG_CYCLES - 1))
		else $error("program busy count not loaded");

	busy_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R14
		busy_q && cnt_q > CNT_W'(8) |=> busy_q [*8])
		else $error("busy dropped before count ended");

	read_load_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R16
		ev_q && !busy_q && kind_in == OP_READ |=>
		cnt_q == CNT_W'(READ_CYCLES - 1))
		else $error("page read busy count wrong");

	rst_erase_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R17
		ev_q && is_reset && !first_q && busy_q && cur_op_q == OP_ERASE
		|=> cnt_q == CNT_W'(RST_ERASE_CYCLES - 1))
		else $error("reset during erase has wrong limit");

	first_reset_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R18
		ev_q && is_reset && first_q |=>
		!first_q && cnt_q == CNT_W'(RST_FIRST_CYCLES - 1))
		else $error("first reset limit wrong");

	lock_write_a: assert property (@(posedge SPI_SCK) disable iff (RST) // R12
		lock_wr |=> lock_q == $past(rx_byte))
		else $error("lock settings write lost");

	freeze_hold_a: assert property (@(posedge SPI_SCK) disable iff (RST) // R8
		config_q[CFG_FREEZE_BIT] |=> $stable(lock_q))
		else $error("frozen lock settings changed");

	reserved_zero_a: assert property (@(posedge SPI_SCK) disable iff (RST) // R19
		(config_q & ~CONFIG_MASK) == BYTE_ZERO &&
		(drive_q & ~DRIVE_MASK) == BYTE_ZERO)
		else $error("reserved feature bit set");

	get_addr_a: assert property (@(posedge SPI_SCK) disable iff (frame_rst) // R5
		state_q == FR_OPCODE && byte_done && rx_byte == OPC_GET_FEATURE
		|=> state_q == FR_ADDR)
		else $error("get feature did not expect address");

	reset_keep_a: assert property (@(posedge SPI_SCK) disable iff (RST) // R6
		op_start && kind_d == OP_RESET |=>
		$stable(config_q) && $stable(lock_q) && $stable(drive_q))
		else $error("reset opcode changed feature bank");

endmodule : spi_nand_feature_regs

// [src/nand_feature_pkg.sv]
// Purpose: Shared constants and types for the serial flash feature bank.
// Assumes: Core clock of 200 MHz; serial link clocked by the host.
// Notes: Times are kept in their own units; cycle counts derive from them.

package nand_feature_pkg;

	// ==========================================================
	// Command opcodes
	localparam logic [7:0] OPC_GET_FEATURE = 8'h0F;
	localparam logic [7:0] OPC_SET_FEATURE = 8'h1F;
	localparam logic [7:0] OPC_PROGRAM_EXEC = 8'h10;
	localparam logic [7:0] OPC_PAGE_READ = 8'h13;
	localparam logic [7:0] OPC_RESET = 8'hFF;

	// ==========================================================
	// Feature addresses
	localparam logic [7:0] ADDR_LOCK = 8'hA0;
	localparam logic [7:0] ADDR_CONFIG = 8'hB0;
	localparam logic [7:0] ADDR_STATUS = 8'hC0;
	localparam logic [7:0] ADDR_DRIVE = 8'hD0;

	// ==========================================================
	// Reset values and implemented-bit masks
	localparam logic [7:0] LOCK_RESET = 8'h7C;
	localparam logic [7:0] CONFIG_RESET = 8'h10;
	localparam logic [7:0] DRIVE_RESET = 8'h00;
	localparam logic [7:0] LOCK_MASK = 8'hFF;
	localparam logic [7:0] CONFIG_MASK = 8'hF0;
	localparam logic [7:0] STATUS_MASK = 8'h3F;
	localparam logic [7:0] DRIVE_MASK = 8'h60;
	localparam logic [7:0] CFG_VOLATILE_MASK = 8'h50;
	localparam logic [7:0] CFG_STICKY_MASK = 8'hA0;
	localparam logic [7:0] CFG_OTP_LOCK_MASK = 8'h80;
	localparam logic [7:0] CFG_FREEZE_MASK = 8'h20;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ==========================================================
	// Field positions
	localparam int LOCK_GUARD_A_BIT = 7;
	localparam int LOCK_GUARD_B_BIT = 0;
	localparam int CFG_FREEZE_BIT = 5;
	localparam int DRV_HI_BIT = 6;
	localparam int DRV_LO_BIT = 5;
	localparam int STAT_W = 6;

	// ==========================================================
	// Serial framing
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// ==========================================================
	// Busy timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int NS_PER_US = 1000;
	localparam int PROG_TIME_US = 400;
	localparam int READ_TIME_US = 100;
	localparam int ERASE_TIME_US = 4000;
	localparam int RST_IDLE_US = 5;
	localparam int RST_READ_US = 5;
	localparam int RST_PROG_US = 10;
	localparam int RST_ERASE_US = 500;
	localparam int RST_FIRST_US = 1000;
	localparam int PROG_CYC = PROG_TIME_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int READ_CYC = READ_TIME_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int ERASE_CYC = ERASE_TIME_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int RST_IDLE_CYC = RST_IDLE_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int RST_READ_CYC = RST_READ_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int RST_PROG_CYC = RST_PROG_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int RST_ERASE_CYC = RST_ERASE_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int RST_FIRST_CYC = RST_FIRST_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int CNT_W = 24;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {OP_PROGRAM, OP_READ, OP_ERASE, OP_RESET}
		op_kind_type;
	typedef enum logic [1:0] {FR_OPCODE, FR_ADDR, FR_DATA, FR_IGNORE}
		frame_state_type;

	// Implemented bits of each feature address; others read zero
	function automatic logic [7:0] feature_mask(input logic [7:0] addr);
		logic [7:0] m;
		m = BYTE_ZERO;
		case (addr)
			ADDR_LOCK: m = LOCK_MASK;
			ADDR_CONFIG: m = CONFIG_MASK;
			ADDR_STATUS: m = STATUS_MASK;
			ADDR_DRIVE: m = DRIVE_MASK;
			default: m = BYTE_ZERO;
		endcase
		return m;
	endfunction : feature_mask

endpackage : nand_feature_pkg

// [src/bit_sync.sv]
// Purpose: Two-stage synchroniser for slow levels.
// Assumes: Each bit is an independent level, held for several cycles.
// Notes: Only the second stage is meant to be read.

`timescale 1ns/1ps

module bit_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level in and synchronised level out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : bit_sync

// [sim/spi_host_model.sv]
// Purpose: Host side of the serial link, frame by frame.
// Assumes: Link half period of 24 ns; one frame per call.
// Notes: Undriven read bits come back as X so they never match.

`timescale 1ns/1ps

module spi_host_model (
	// Serial link towards the device
	output logic sck,
	output logic cs_n,
	output logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	// ==========================================================
	// Idle link
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// ==========================================================
	// One framed transfer, MSB first, n bits taken from tx[23] down
	task automatic xfer(input bit m3, input logic [23:0] tx, input int n,
		output logic [7:0] rx);
		rx = 8'hxx;
		sck = m3;
		#24;
		cs_n = 1'b0;
		#24;
		for (int i = 0; i < n; i++) begin
			// Launch on the low phase, capture on the rising edge
			sck = 1'b0;
			mosi = tx[23-i];
			#24;
			sck = 1'b1;
			rx = {rx[6:0], miso_oe ? miso : 1'bx};
			#24;
		end
		sck = m3;
		#24;
		cs_n = 1'b1;
		// Released line shows the inverse, not a stale value
		mosi = ~mosi;
		#120;
	endtask : xfer
endmodule : spi_host_model

// [sim/test_spi_nand_feature_regs.sv]
// Purpose: Self-checking bench for the feature bank and busy timing.
// Assumes: Short busy counts set by parameter; link from the host model.
// Notes: Each scenario task drives the block and judges what comes back.

`timescale 1ns/1ps

`define CHK(g, e) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); \
	end \
end

module test_spi_nand_feature_regs import nand_feature_pkg::*;;
	// ==========================================================
	// Shortened busy limits, in core cycles
	localparam int PROG_C = 1000;
	localparam int READ_C = 300;
	localparam int ERASE_C = 500;
	localparam int RI = 100;
	localparam int RF = 200;

	logic CORE_CLK, RST, SPI_SCK, SPI_CS_N, SPI_MOSI;
	logic SPI_MISO_O, SPI_MISO_OE, PROGRAM_FAIL, ERASE_FAIL, WRITE_LATCH;
	logic [1:0] ECC_STATUS, DRIVE_STRENGTH;
	logic [7:0] LOCK_SETTINGS, CONFIG_SETTINGS, d;
	logic OP_BUSY;
	int num_errors, num_checks, bcnt;
	bit m3;

	spi_nand_feature_regs #(.PROG_CYCLES(PROG_C), .READ_CYCLES(READ_C),
		.ERASE_CYCLES(ERASE_C), .RST_IDLE_CYCLES(RI),
		.RST_READ_CYCLES(110), .RST_PROG_CYCLES(120),
		.RST_ERASE_CYCLES(130), .RST_FIRST_CYCLES(RF)) DUT (
		.CORE_CLK(CORE_CLK), .RST(RST), .SPI_SCK(SPI_SCK),
		.SPI_CS_N(SPI_CS_N), .SPI_MOSI(SPI_MOSI),
		.SPI_MISO_O(SPI_MISO_O), .SPI_MISO_OE(SPI_MISO_OE),
		.ECC_STATUS(ECC_STATUS), .PROGRAM_FAIL(PROGRAM_FAIL),
		.ERASE_FAIL(ERASE_FAIL), .WRITE_LATCH(WRITE_LATCH),
		.LOCK_SETTINGS(LOCK_SETTINGS), .CONFIG_SETTINGS(CONFIG_SETTINGS),
		.DRIVE_STRENGTH(DRIVE_STRENGTH), .OP_BUSY(OP_BUSY));

	spi_host_model host (.sck(SPI_SCK), .cs_n(SPI_CS_N), .mosi(SPI_MOSI),
		.miso(SPI_MISO_O), .miso_oe(SPI_MISO_OE));

	// ==========================================================
	// Clock and busy-length monitor
	always #2.5 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK) if (OP_BUSY === 1'b1) bcnt <= bcnt + 1;

	// ==========================================================
	// Link helpers
	task automatic get(input logic [7:0] a, output logic [7:0] r);
		host.xfer(m3, {OPC_GET_FEATURE, a, 8'h00}, 24, r);
	endtask : get

	task automatic set(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] r;
		host.xfer(m3, {OPC_SET_FEATURE, a, v}, 24, r);
	endtask : set

	function automatic logic [7:0] stat(input logic b);
		return {2'b00, ECC_STATUS, PROGRAM_FAIL, ERASE_FAIL, WRITE_LATCH, b};
	endfunction : stat

	// Bounded wait for the busy flag to drop after it was seen
	task automatic wait_idle;
		repeat (3000) begin
			@(negedge CORE_CLK);
			if (bcnt != 0 && OP_BUSY === 1'b0) break;
		end
	endtask : wait_idle

	// Issue one array opcode and measure how long busy stands
	task automatic op(input logic [7:0] c, input int lim);
		@(negedge CORE_CLK);
		bcnt = 0;
		host.xfer(m3, {c, 16'h0000}, 8, d);
		wait_idle();
		`CHK(bcnt, lim)
	endtask : op

	// ==========================================================
	// Scenarios
	task automatic sc_power;
		get(ADDR_LOCK, d);
		`CHK(d, 8'h7C)
		`CHK(LOCK_SETTINGS, 8'h7C)
		get(ADDR_CONFIG, d);
		`CHK(d, 8'h10)
		get(ADDR_DRIVE, d);
		`CHK(d, 8'h00)
	endtask : sc_power

	task automatic sc_write;
		m3 = 1'b1;
		set(ADDR_LOCK, 8'h83);
		get(ADDR_LOCK, d);
		`CHK(d, 8'h83)
		set(ADDR_DRIVE, 8'hFF);
		get(ADDR_DRIVE, d);
		`CHK(d, 8'h60)
		`CHK(DRIVE_STRENGTH, 2'b11)
		m3 = 1'b0;
		set(ADDR_CONFIG, 8'h4F);
		get(ADDR_CONFIG, d);
		`CHK(d, 8'h40)
		set(ADDR_STATUS, 8'hFF);
		get(ADDR_STATUS, d);
		`CHK(d, stat(1'b0))
		set(8'hE0, 8'hFF);
		get(8'hE0, d);
		`CHK(d, 8'h00)
		`CHK(CONFIG_SETTINGS, 8'h40)
	endtask : sc_write

	task automatic sc_status;
		@(negedge CORE_CLK);
		{ECC_STATUS, PROGRAM_FAIL, ERASE_FAIL, WRITE_LATCH} = 5'b10101;
		get(ADDR_STATUS, d);
		`CHK(d, 8'h2A)
		@(negedge CORE_CLK);
		{ECC_STATUS, PROGRAM_FAIL, ERASE_FAIL, WRITE_LATCH} = 5'b01010;
		get(ADDR_STATUS, d);
		`CHK(d, 8'h14)
	endtask : sc_status

	task automatic sc_busy;
		op(OPC_RESET, RF);
		op(OPC_RESET, RI);
		`CHK(LOCK_SETTINGS, 8'h83)
		get(ADDR_CONFIG, d);
		`CHK(d, 8'h40)
		op(OPC_PAGE_READ, READ_C);
		op(8'hD8, ERASE_C);
		// A read issued mid-program must not stretch the busy time
		@(negedge CORE_CLK);
		bcnt = 0;
		host.xfer(m3, {OPC_PROGRAM_EXEC, 16'h0000}, 8, d);
		host.xfer(m3, {OPC_PAGE_READ, 16'h0000}, 8, d);
		get(ADDR_STATUS, d);
		`CHK(d, stat(1'b1))
		wait_idle();
		`CHK(bcnt, PROG_C)
		// Reset mid-erase cuts busy short to the erase reset limit
		@(negedge CORE_CLK);
		bcnt = 0;
		host.xfer(m3, {8'hD8, 16'h0000}, 8, d);
		host.xfer(m3, {OPC_RESET, 16'h0000}, 8, d);
		wait_idle();
		`CHK((bcnt >= 130 && bcnt < ERASE_C), 1'b1)
		`CHK(SPI_MISO_OE, 1'b0)
	endtask : sc_busy

	task automatic sc_guard;
		set(ADDR_LOCK, 8'h01);
		set(ADDR_LOCK, 8'hFF);
		get(ADDR_LOCK, d);
		`CHK(d, 8'h01)
		// Power cycle clears the lock-down
		@(negedge CORE_CLK);
		RST = 1'b1;
		repeat (4) @(negedge CORE_CLK);
		RST = 1'b0;
		repeat (2) @(negedge CORE_CLK);
		get(ADDR_LOCK, d);
		`CHK(d, 8'h7C)
		`CHK(CONFIG_SETTINGS, 8'h10)
		set(ADDR_LOCK, 8'h81);
		set(ADDR_CONFIG, 8'h30);
		get(ADDR_CONFIG, d);
		`CHK(d, 8'h30)
		set(ADDR_LOCK, 8'h00);
		get(ADDR_LOCK, d);
		`CHK(d, 8'h81)
		set(ADDR_CONFIG, 8'h10);
		get(ADDR_CONFIG, d);
		`CHK(d, 8'h30)
	endtask : sc_guard

	// ==========================================================
	// Verdict, the single exit of the run
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// Watchdog sized well above the expected run of about 50 us
	initial begin
		#400000;
		num_errors++;
		$display("ERROR %0t: watchdog expired", $time);
		finish_test();
	end

	initial begin
		CORE_CLK = 1'b0;
		RST = 1'b1;
		{ECC_STATUS, PROGRAM_FAIL, ERASE_FAIL, WRITE_LATCH} = 5'b00000;
		num_errors = 0;
		num_checks = 0;
		bcnt = 0;
		m3 = 1'b0;
		repeat (4) @(negedge CORE_CLK);
		RST = 1'b0;
		repeat (2) @(negedge CORE_CLK);
		sc_power();
		sc_write();
		sc_status();
		sc_busy();
		sc_guard();
		finish_test();
	end
endmodule : test_spi_nand_feature_regs
